/* File: rtl/cfg_link_if.sv */
`timescale 1ns/1ps
`default_nettype none
interface cfg_link_if;
    logic sclk;
    logic select_n;
    logic host_sdio_out;
    logic host_sdio_oe_n;
    logic dev_sdio_out;
    logic dev_sdio_oe_n;
    logic sdio;

    // shared data pin: undriven floats to the strap default (high)
    assign sdio = !host_sdio_oe_n ? host_sdio_out : (!dev_sdio_oe_n ? dev_sdio_out : 1'b1);

    modport device (input sclk, input select_n, input sdio, output dev_sdio_out, output dev_sdio_oe_n);
    modport host (output sclk, output select_n, output host_sdio_out, output host_sdio_oe_n, input sdio);
endinterface
`default_nettype wire

/* File: rtl/cfg_pin_sync.sv */
`timescale 1ns/1ps
`default_nettype none
module cfg_pin_sync #(
    parameter int W = 1
) (
    input wire logic clk,
    input wire logic reset_n,
    input wire logic [W-1:0] pin_async,
    output logic [W-1:0] level,
    output logic [W-1:0] rise,
    output logic [W-1:0] fall
);
    logic [W-1:0] meta_q;
    logic [W-1:0] sync_q;
    logic [W-1:0] last_q;

    // ==========================================
    // two-stage synchroniser, edges found after the second stage
    always_ff @(posedge clk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            meta_q <= '1;
            sync_q <= '1;
            last_q <= '1;
        end
        else
        begin
            meta_q <= pin_async;
            sync_q <= meta_q;
            last_q <= sync_q;
        end
    end

    assign level = sync_q;
    assign rise = sync_q & ~last_q;
    assign fall = ~sync_q & last_q;
endmodule
`default_nettype wire

/* File: rtl/cfg_port_device.sv */
// The APB slave port and the register addresses were chosen for this implementation.
`timescale 1ns/1ps
`default_nettype none
// Contract
// - select low gates every read and write
// - frame starts: select falls, then clock rises
// - select held low streams indefinitely
// - select high between bytes stalls, then resumes; in streaming it ends the frame
// - select high: data pin released, static functions
// - sixteen-bit instruction precedes all data
// - two length bits set data word count
// - data moves in eight-bit words
// - first bit chooses read or write
// - data pin turns around only for read data
// - clock and select are device inputs only
// - msb first by default, lsb by config
// - data pin level strapped at power-on
// - strap high: full power-down; low: normal
// - output-enable high puts data buses hiz
// - select tied high: port off, pins static
// - shadow registers load on transfer bit, autoclear
module cfg_port_device
    import cfg_port_pkg::*;
#(
    parameter logic [7:0] CHIP_ID = 8'h5C // arbitrary value
) (
    input wire logic clk,
    input wire logic reset_n,
    cfg_link_if.device link,
    input wire logic output_enable_n,
    output logic chip_powerdown,
    output logic data_bus_hiz,
    output logic lsb_first,
    output logic [7:0] power_mode
);
    logic [3:0] lvl;
    logic [3:0] rise;
    logic [3:0] fall;
    dev_state_t state_q;
    logic [3:0] bit_cnt_q;
    logic [14:0] instr_q;
    logic [7:0] rx_q;
    logic [7:0] tx_q;
    logic [7:0] addr_q;
    logic rd_q;
    logic stream_q;
    logic [1:0] words_left_q;
    logic lsb_q;
    logic [7:0] shadow_q [PROG_COUNT];
    logic [7:0] active_q [PROG_COUNT];
    logic dev_out_q;
    logic dev_oe_n_q;
    logic [1:0] strap_cnt_q;
    logic strap_done_q;
    logic strap_q;
    logic pd_q;
    logic hiz_q;

    // ==========================================
    // pin sampling: 0 select, 1 clock, 2 data, 3 output enable
    cfg_pin_sync #(.W(4)) u_sync (
        .clk(clk),
        .reset_n(reset_n),
        .pin_async({output_enable_n, link.sdio, link.sclk, link.select_n}),
        .level(lvl),
        .rise(rise),
        .fall(fall)
    );

    logic sel_low;
    logic clk_rise;
    logic clk_fall;
    logic din;
    logic [15:0] instr_full;
    logic [7:0] wbyte;
    logic instr_end;
    logic byte_end;
    logic wr_stb;
    logic [7:0] next_addr;

    assign sel_low = !lvl[0];
    assign clk_rise = rise[1] && sel_low;
    assign clk_fall = fall[1] && sel_low;
    assign din = lvl[2];
    assign instr_full = {instr_q, din};
    assign wbyte = lsb_q ? {din, rx_q[7:1]} : {rx_q[6:0], din};
    assign instr_end = clk_rise && state_q == DEV_INSTR && bit_cnt_q == 4'(INSTR_BITS - 1);
    assign byte_end = clk_rise && state_q == DEV_DATA && bit_cnt_q[2:0] == 3'(WORD_BITS - 1);
    assign wr_stb = byte_end && !rd_q;
    assign next_addr = lsb_q ? addr_q + 8'h01 : addr_q - 8'h01;

    function automatic logic in_prog(input logic [7:0] a);
        in_prog = a >= ADDR_PROG_FIRST && a <= ADDR_PROG_LAST;
    endfunction

    function automatic logic [7:0] reg_read(input logic [7:0] a);
        logic [7:0] idx;
        idx = a - ADDR_PROG_FIRST;
        if (a == ADDR_PORT_CFG)
            reg_read = {1'b0, lsb_q, 2'b01, 1'b1, 1'b0, lsb_q, 1'b0};
        else if (a == ADDR_CHIP_ID)
            reg_read = CHIP_ID;
        else if (in_prog(a))
            reg_read = shadow_q[idx[4:0]];
        else
            reg_read = 8'h00;
    endfunction

    // ==========================================
    // frame sequencing
    always_ff @(posedge clk or negedge reset_n)
    begin
        if (!reset_n)
            state_q <= DEV_IDLE;
        else if (!sel_low)
        begin
            if (state_q == DEV_DONE || (state_q == DEV_DATA && stream_q) || bit_cnt_q[2:0] != 3'h0)
                state_q <= DEV_IDLE;
        end // stall at a byte boundary keeps a non-streaming frame
        else
        begin
            unique case (state_q)
                DEV_IDLE: state_q <= DEV_INSTR;
                DEV_INSTR:
                    if (instr_end)
                        state_q <= DEV_DATA;
                DEV_DATA:
                    if (byte_end && !stream_q && words_left_q == 2'h0)
                        state_q <= DEV_DONE;
                DEV_DONE: state_q <= DEV_DONE;
            endcase
        end
    end

    always_ff @(posedge clk or negedge reset_n)
    begin
        if (!reset_n)
            bit_cnt_q <= 4'h0;
        else if (state_q == DEV_IDLE)
            bit_cnt_q <= 4'h0;
        else if (clk_rise && state_q == DEV_DATA)
            bit_cnt_q <= {1'b0, bit_cnt_q[2:0] + 3'h1};
        else if (clk_rise && state_q == DEV_INSTR)
            bit_cnt_q <= bit_cnt_q + 4'h1;
    end

    // ==========================================
    // shifting and addressing
    always_ff @(posedge clk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            instr_q <= '0;
            rx_q <= 8'h00;
        end
        else if (clk_rise && state_q == DEV_INSTR)
            instr_q <= instr_full[14:0];
        else if (clk_rise && state_q == DEV_DATA)
            rx_q <= wbyte;
    end

    always_ff @(posedge clk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            rd_q <= 1'b0;
            stream_q <= 1'b0;
            words_left_q <= 2'h0;
            addr_q <= 8'h00;
            tx_q <= 8'h00;
        end
        else if (instr_end)
        begin
            rd_q <= instr_full[INSTR_RW_POS];
            words_left_q <= instr_full[INSTR_WLEN_POS +: 2];
            stream_q <= instr_full[INSTR_WLEN_POS +: 2] == WLEN_STREAM;
            addr_q <= instr_full[7:0];
            tx_q <= reg_read(instr_full[7:0]);
        end
        else if (byte_end)
        begin
            addr_q <= next_addr;
            tx_q <= reg_read(next_addr);
            if (!stream_q)
                words_left_q <= words_left_q - 2'h1;
        end
    end

    // ==========================================
    // register file
    always_ff @(posedge clk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            lsb_q <= 1'b0;
            for (int i = 0; i < PROG_COUNT; i++)
            begin
                shadow_q[i] <= PROG_RESET;
                active_q[i] <= PROG_RESET;
            end
        end
        else if (wr_stb && addr_q == ADDR_PORT_CFG)
        begin
            lsb_q <= wbyte[CFG_LSB_HI_POS] | wbyte[CFG_LSB_LO_POS];
            if (wbyte[CFG_SRST_HI_POS] | wbyte[CFG_SRST_LO_POS])
            begin
                lsb_q <= 1'b0;
                for (int i = 0; i < PROG_COUNT; i++)
                begin
                    shadow_q[i] <= PROG_RESET;
                    active_q[i] <= PROG_RESET;
                end
            end
        end
        else if (wr_stb && in_prog(addr_q))
            shadow_q[5'(addr_q - ADDR_PROG_FIRST)] <= wbyte;
        else if (wr_stb && addr_q == ADDR_TRANSFER && wbyte[TRANSFER_POS])
            for (int i = 0; i < PROG_COUNT; i++)
                active_q[i] <= shadow_q[i];
    end

    // ==========================================
    // read data pin drive
    always_ff @(posedge clk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            dev_oe_n_q <= 1'b1;
            dev_out_q <= 1'b1;
        end
        else if (!sel_low)
            dev_oe_n_q <= 1'b1;
        else if (clk_fall)
        begin
            dev_oe_n_q <= !(state_q == DEV_DATA && rd_q);
            dev_out_q <= pick_bit(tx_q, bit_cnt_q[2:0], lsb_q);
        end
    end

    // ==========================================
    // straps and static controls
    always_ff @(posedge clk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            strap_cnt_q <= 2'h0;
            strap_done_q <= 1'b0;
            strap_q <= 1'b1;
        end
        else if (!strap_done_q)
        begin
            strap_cnt_q <= strap_cnt_q + 2'h1;
            if (strap_cnt_q == STRAP_WAIT)
            begin
                strap_done_q <= 1'b1;
                strap_q <= din;
            end
        end
    end

    always_ff @(posedge clk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            pd_q <= 1'b1;
            hiz_q <= 1'b1;
        end
        else
        begin
            pd_q <= !strap_done_q || strap_q || active_q[0][1:0] == PWR_MODE_DOWN;
            hiz_q <= lvl[3] || pd_q;
        end
    end

    assign link.dev_sdio_out = dev_out_q;
    assign link.dev_sdio_oe_n = dev_oe_n_q;
    assign chip_powerdown = pd_q;
    assign data_bus_hiz = hiz_q;
    assign lsb_first = lsb_q;
    assign power_mode = active_q[0];
endmodule
`default_nettype wire

/* File: rtl/cfg_port_host.sv */
`timescale 1ns/1ps
`default_nettype none
module cfg_port_host
    import cfg_port_pkg::*;
(
    input wire logic clk,
    input wire logic reset_n,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    cfg_link_if.host link
);
    host_state_t state_q;
    logic [3:0] div_q;
    logic [5:0] bit_q;
    logic rd_q;
    logic [1:0] wlen_q;
    logic lsb_q;
    logic [12:0] addr_q;
    logic [31:0] wdata_q;
    logic [31:0] rdata_q;
    logic done_q;
    logic pready_q;
    logic pslverr_q;
    logic [31:0] prdata_q;
    logic sclk_q;
    logic sel_n_q;
    logic out_q;
    logic oe_n_q;
    logic sdio_lvl;

    cfg_pin_sync #(.W(1)) u_sync (
        .clk(clk),
        .reset_n(reset_n),
        .pin_async(link.sdio),
        .level(sdio_lvl),
        .rise(),
        .fall()
    );

    logic acc;
    logic wr_acc;
    logic start;
    logic half_done;
    logic [5:0] last_bit;
    logic [5:0] dbit;
    logic [5:0] nbit;
    logic [15:0] instr;
    logic busy;

    assign acc = psel && penable && pready_q;
    assign wr_acc = acc && pwrite;
    assign busy = state_q != HOST_IDLE;
    assign start = wr_acc && paddr == HOST_CTRL && pwdata[CTRL_START_POS] && !busy;
    assign half_done = div_q == SCLK_HALF_CYC - 4'h1;
    assign last_bit = 6'(INSTR_BITS - 1) + {1'b0, wlen_q, 3'h7} + 6'h1;
    assign dbit = bit_q - 6'(INSTR_BITS);
    assign nbit = bit_q + 6'h1;
    assign instr = {rd_q, wlen_q, addr_q};

    function automatic logic frame_bit(input logic [5:0] b);
        logic [5:0] d;
        d = b - 6'(INSTR_BITS);
        if (b < 6'(INSTR_BITS))
            frame_bit = instr[4'(15 - b)];
        else
            frame_bit = pick_bit(wdata_q[{d[4:3], 3'h0} +: 8], d[2:0], lsb_q);
    endfunction

    // ==========================================
    // apb slave
    always_ff @(posedge clk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            pready_q <= 1'b0;
            pslverr_q <= 1'b0;
            prdata_q <= 32'h0;
        end
        else
        begin
            pready_q <= psel && penable && !pready_q;
            pslverr_q <= !(paddr == HOST_CTRL || paddr == HOST_ADDR || paddr == HOST_WDATA
                || paddr == HOST_RDATA || paddr == HOST_STATUS);
            unique case (paddr)
                HOST_CTRL: prdata_q <= {27'h0, lsb_q, wlen_q, rd_q, 1'b0};
                HOST_ADDR: prdata_q <= {19'h0, addr_q};
                HOST_WDATA: prdata_q <= wdata_q;
                HOST_RDATA: prdata_q <= rdata_q;
                HOST_STATUS: prdata_q <= {30'h0, done_q, busy};
                default: prdata_q <= 32'h0;
            endcase
        end
    end

    always_ff @(posedge clk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            rd_q <= 1'b0;
            wlen_q <= 2'h0;
            lsb_q <= 1'b0;
            addr_q <= 13'h0;
            wdata_q <= 32'h0;
        end
        else if (wr_acc && !busy)
        begin
            if (paddr == HOST_CTRL)
            begin
                rd_q <= pwdata[CTRL_READ_POS];
                wlen_q <= pwdata[CTRL_WLEN_POS +: 2];
                lsb_q <= pwdata[CTRL_LSB_POS];
            end
            if (paddr == HOST_ADDR)
                addr_q <= pwdata[12:0];
            if (paddr == HOST_WDATA)
                wdata_q <= pwdata;
        end
    end

    always_ff @(posedge clk or negedge reset_n)
    begin
        if (!reset_n)
            done_q <= 1'b0;
        else if (state_q == HOST_GAP && half_done)
            done_q <= 1'b1;
        else if (wr_acc && paddr == HOST_STATUS && pwdata[STAT_DONE_POS])
            done_q <= 1'b0;
    end

    // ==========================================
    // serial frame engine
    always_ff @(posedge clk or negedge reset_n)
    begin
        if (!reset_n)
            div_q <= 4'h0;
        else if (state_q == HOST_IDLE || half_done)
            div_q <= 4'h0;
        else
            div_q <= div_q + 4'h1;
    end

    always_ff @(posedge clk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            state_q <= HOST_IDLE;
            bit_q <= 6'h0;
            sclk_q <= 1'b0;
            sel_n_q <= 1'b1;
            out_q <= 1'b1;
            oe_n_q <= 1'b1;
            rdata_q <= 32'h0;
        end
        else
        begin
            unique case (state_q)
                HOST_IDLE:
                    if (start)
                    begin
                        state_q <= HOST_SETUP;
                        bit_q <= 6'h0;
                        sel_n_q <= 1'b0;
                        out_q <= pwdata[CTRL_READ_POS];
                        oe_n_q <= 1'b0;
                    end
                HOST_SETUP, HOST_LOW:
                    if (half_done)
                    begin
                        state_q <= HOST_HIGH;
                        sclk_q <= 1'b1;
                    end
                HOST_HIGH:
                    if (half_done)
                    begin
                        sclk_q <= 1'b0;
                        if (rd_q && bit_q >= 6'(INSTR_BITS))
                            rdata_q[{dbit[4:3], lsb_q ? dbit[2:0] : ~dbit[2:0]}] <= sdio_lvl;
                        if (bit_q == last_bit)
                        begin
                            state_q <= HOST_GAP;
                            oe_n_q <= 1'b1;
                        end
                        else
                        begin
                            state_q <= HOST_LOW;
                            bit_q <= nbit;
                            out_q <= frame_bit(nbit);
                            oe_n_q <= rd_q && nbit >= 6'(INSTR_BITS);
                        end
                    end
                HOST_GAP:
                    if (half_done)
                    begin
                        state_q <= HOST_IDLE;
                        sel_n_q <= 1'b1;
                    end
            endcase
        end
    end

    assign prdata = prdata_q;
    assign pready = pready_q;
    assign pslverr = pslverr_q;
    assign link.sclk = sclk_q;
    assign link.select_n = sel_n_q;
    assign link.host_sdio_out = out_q;
    assign link.host_sdio_oe_n = oe_n_q;
endmodule
`default_nettype wire

/* File: rtl/cfg_port_pkg.sv */
package cfg_port_pkg;

    // ==========================================
    // serial frame layout
    localparam int INSTR_BITS = 16;
    localparam int WORD_BITS = 8;
    localparam int INSTR_RW_POS = 15;
    localparam int INSTR_WLEN_POS = 13;
    localparam logic [1:0] WLEN_STREAM = 2'h3;

    // ==========================================
    // device register map
    localparam logic [7:0] ADDR_PORT_CFG = 8'h00;
    localparam logic [7:0] ADDR_CHIP_ID = 8'h01;
    localparam logic [7:0] ADDR_PROG_FIRST = 8'h08;
    localparam logic [7:0] ADDR_PROG_LAST = 8'h25;
    localparam logic [7:0] ADDR_TRANSFER = 8'hFF;
    localparam int PROG_COUNT = 30;
    localparam logic [7:0] PROG_RESET = 8'h00;
    localparam int CFG_LSB_HI_POS = 6;
    localparam int CFG_SRST_HI_POS = 5;
    localparam int CFG_SRST_LO_POS = 2;
    localparam int CFG_LSB_LO_POS = 1;
    localparam int TRANSFER_POS = 0;
    localparam logic [1:0] PWR_MODE_DOWN = 2'h1;
    localparam logic [1:0] STRAP_WAIT = 2'h3;

    // ==========================================
    // controller register map (apb)
    localparam logic [7:0] HOST_CTRL = 8'h00;
    localparam logic [7:0] HOST_ADDR = 8'h04;
    localparam logic [7:0] HOST_WDATA = 8'h08;
    localparam logic [7:0] HOST_RDATA = 8'h0C;
    localparam logic [7:0] HOST_STATUS = 8'h10;
    localparam int CTRL_START_POS = 0;
    localparam int CTRL_READ_POS = 1;
    localparam int CTRL_WLEN_POS = 2;
    localparam int CTRL_LSB_POS = 4;
    localparam int STAT_BUSY_POS = 0;
    localparam int STAT_DONE_POS = 1;

    // ==========================================
    // timing
    localparam int CLK_PERIOD_NS = 100;
    localparam int SCLK_HALF_NS = 400;
    localparam logic [3:0] SCLK_HALF_CYC = 4'(SCLK_HALF_NS / CLK_PERIOD_NS);

    typedef enum logic [3:0] {
        DEV_IDLE = 4'h1,
        DEV_INSTR = 4'h2,
        DEV_DATA = 4'h4,
        DEV_DONE = 4'h8
    } dev_state_t;

    typedef enum logic [4:0] {
        HOST_IDLE = 5'h01,
        HOST_SETUP = 5'h02,
        HOST_LOW = 5'h04,
        HOST_HIGH = 5'h08,
        HOST_GAP = 5'h10
    } host_state_t;

    // bit j of a word in the chosen shift order
    function automatic logic pick_bit(input logic [7:0] word, input logic [2:0] j, input logic lsb);
        pick_bit = lsb ? word[j] : word[3'h7 - j];
    endfunction

endpackage

/* File: testbench/cfg_link_sva.sv */
`timescale 1ns/1ps
`default_nettype none
module cfg_link_sva (
    input wire logic clk,
    input wire logic reset_n,
    input wire logic sclk,
    input wire logic select_n,
    input wire logic host_sdio_out,
    input wire logic host_sdio_oe_n,
    input wire logic dev_sdio_out,
    input wire logic dev_sdio_oe_n
);
    default clocking @(posedge clk); endclocking
    default disable iff (!reset_n);
    logic sclk_q;
    logic [7:0] bits_q;

    // ==========================================
    // serial clock rises seen in the current frame
    always_ff @(posedge clk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            sclk_q <= 1'h0;
            bits_q <= 8'h00;
        end
        else
        begin
            sclk_q <= sclk;
            if (select_n)
                bits_q <= 8'h00;
            else if (sclk && !sclk_q)
                bits_q <= bits_q + 8'h01;
        end
    end

    // ==========================================
    // wire checks
    sclk_idle_a: assert property (select_n |-> !sclk)
        else $error("serial clock high while deselected");
    frame_start_a: assert property ($fell(select_n) |-> !sclk [*4])
        else $error("serial clock rose too soon after select");
    half_period_a: assert property ($rose(sclk) |-> sclk [*4] ##1 !sclk)
        else $error("serial clock high phase wrong");
    frame_len_a: assert property ($rose(select_n) |-> bits_q >= 8'h18 && bits_q[2:0] == 3'h0)
        else $error("frame not instruction plus whole words");
    no_clash_a: assert property (!(!host_sdio_oe_n && !dev_sdio_oe_n))
        else $error("both ends drive the data pin");
    dev_release_a: assert property (select_n [*6] |-> dev_sdio_oe_n)
        else $error("device drives while deselected");
    turn_late_a: assert property (!dev_sdio_oe_n && !select_n |-> bits_q >= 8'h10)
        else $error("device drives before instruction end");
    host_hold_a: assert property (!host_sdio_oe_n && sclk |-> $stable(host_sdio_out))
        else $error("host data moved while clock high");
    dev_hold_a: assert property (!dev_sdio_oe_n && sclk && $past(sclk, 2) |-> $stable(dev_sdio_out))
        else $error("device data moved while clock high");

    read_cov_c: cover property ($fell(dev_sdio_oe_n));
    word_cov_c: cover property ($rose(select_n) && bits_q == 8'h18);
    stream_cov_c: cover property ($rose(select_n) && bits_q == 8'h30);
endmodule
`default_nettype wire

/* File: testbench/tb_adc_serial_config_port.sv */
`timescale 1ns/1ps
`default_nettype none
module tb_adc_serial_config_port import cfg_port_pkg::*;;
    localparam logic [7:0] ID_EXP = 8'h3B; // arbitrary identity value
    logic clk, reset_n, psel, penable, pwrite, pslverr, pready, oe_n, pd, hiz, lsb;
    logic [7:0] paddr, pmode;
    logic [31:0] pwdata, prdata;
    int error_cnt = 0;
    int n_tests = 0;
    cfg_link_if link();
    cfg_port_host u_cfg_port_host (.clk(clk), .reset_n(reset_n), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .link(link));
    cfg_port_device #(.CHIP_ID(ID_EXP)) u_cfg_port_device (.clk(clk), .reset_n(reset_n), .link(link),
        .output_enable_n(oe_n), .chip_powerdown(pd), .data_bus_hiz(hiz), .lsb_first(lsb), .power_mode(pmode));
    cfg_link_sva u_cfg_link_sva (.clk(clk), .reset_n(reset_n), .sclk(link.sclk), .select_n(link.select_n),
        .host_sdio_out(link.host_sdio_out), .host_sdio_oe_n(link.host_sdio_oe_n),
        .dev_sdio_out(link.dev_sdio_out), .dev_sdio_oe_n(link.dev_sdio_oe_n));

    // ==========================================
    // shared tasks
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        n_tests++;
        if (got !== exp)
        begin
            error_cnt++;
            $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    task automatic final_report;
        $display("checks=%0d mismatches=%0d", n_tests, error_cnt);
        if (error_cnt == 0 && n_tests > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask

    task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] wd, output logic [31:0] rd,
        output logic err);
        psel <= 1'h1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= wd;
        @(posedge clk);
        penable <= 1'h1;
        do
        begin
            @(posedge clk);
        end
        while (pready !== 1'h1);
        rd = prdata;
        err = pslverr;
        psel <= 1'h0;
        penable <= 1'h0;
        @(posedge clk);
    endtask

    // one serial frame through the controller, returning read data
    task automatic xfer(input logic rd, input logic [1:0] wl, input logic ls, input logic [7:0] a,
        input logic [31:0] wd, output logic [31:0] q);
        logic [31:0] st;
        logic e;
        int n;
        apb(1'h1, HOST_ADDR, {24'h0, a}, st, e);
        apb(1'h1, HOST_WDATA, wd, st, e);
        apb(1'h1, HOST_CTRL, 32'(ls) << CTRL_LSB_POS | 32'(wl) << CTRL_WLEN_POS | 32'(rd) << CTRL_READ_POS
            | 32'h1 << CTRL_START_POS, st, e);
        n = 0;
        do
        begin
            apb(1'h0, HOST_STATUS, 32'h0, st, e);
            n++;
        end
        while (st[STAT_DONE_POS] !== 1'h1 && n < 500);
        chk(32'(st[STAT_DONE_POS]), 32'h1);
        apb(1'h1, HOST_STATUS, 32'h1 << STAT_DONE_POS, st, e);
        apb(1'h0, HOST_RDATA, 32'h0, q, e);
    endtask

    // ==========================================
    // scenarios
    task automatic t_straps;
        chk(32'(pd), 32'h1);
        chk(32'(lsb), 32'h0);
        chk(32'(pmode), 32'h0);
        oe_n <= 1'h1;
        repeat (6) @(posedge clk);
        chk(32'(hiz), 32'h1);
        oe_n <= 1'h0;
        $display("straps test done");
    endtask

    task automatic t_shadow;
        logic [31:0] q;
        xfer(1'h0, 2'h0, 1'h0, ADDR_PROG_FIRST, 32'hA5, q);
        chk(32'(pmode), 32'h0);
        xfer(1'h0, 2'h0, 1'h0, ADDR_TRANSFER, 32'h1, q);
        chk(32'(pmode), 32'hA5);
        xfer(1'h1, 2'h0, 1'h0, ADDR_TRANSFER, 32'h0, q);
        chk(32'(q[7:0]), 32'h0);
        xfer(1'h1, 2'h0, 1'h0, ADDR_CHIP_ID, 32'h0, q);
        chk(32'(q[7:0]), 32'(ID_EXP));
        $display("shadow test done");
    endtask

    task automatic t_words;
        logic [31:0] q;
        xfer(1'h0, 2'h1, 1'h0, 8'h0A, 32'hC2B1, q);
        xfer(1'h1, 2'h0, 1'h0, 8'h09, 32'h0, q);
        chk(32'(q[7:0]), 32'hC2);
        xfer(1'h1, 2'h1, 1'h0, 8'h0A, 32'h0, q);
        chk(32'(q[15:0]), 32'hC2B1);
        xfer(1'h0, WLEN_STREAM, 1'h0, 8'h10, 32'h44332211, q);
        xfer(1'h1, 2'h0, 1'h0, 8'h0D, 32'h0, q);
        chk(32'(q[7:0]), 32'h44);
        xfer(1'h1, WLEN_STREAM, 1'h0, 8'h10, 32'h0, q);
        chk(q, 32'h44332211);
        $display("word count test done");
    endtask

    task automatic t_order;
        logic [31:0] q;
        xfer(1'h0, 2'h0, 1'h1, 8'h22, 32'h01, q);
        xfer(1'h1, 2'h0, 1'h0, 8'h22, 32'h0, q);
        chk(32'(q[7:0]), 32'h80);
        xfer(1'h0, 2'h0, 1'h0, ADDR_PORT_CFG, 32'h42, q);
        chk(32'(lsb), 32'h1);
        xfer(1'h0, 2'h1, 1'h1, 8'h20, 32'h3C5A, q);
        xfer(1'h1, 2'h0, 1'h1, 8'h21, 32'h0, q);
        chk(32'(q[7:0]), 32'h3C);
        xfer(1'h1, 2'h0, 1'h1, ADDR_PORT_CFG, 32'h0, q);
        chk(32'(q[7:0]), 32'h5A);
        xfer(1'h0, 2'h0, 1'h1, ADDR_PORT_CFG, 32'h24, q);
        chk(32'(lsb), 32'h0);
        chk(32'(pmode), 32'h0);
        $display("bit order test done");
    endtask

    task automatic t_apb_err;
        logic [31:0] q;
        logic e;
        apb(1'h0, 8'h14, 32'h0, q, e);
        chk(32'(e), 32'h1);
        chk(q, 32'h0);
        $display("bus error test done");
    endtask

    // ==========================================
    // clock, watchdog and main sequence
    initial
    begin
        clk = 1'h0;
        forever #50 clk = ~clk;
    end

    initial
    begin
        repeat (40000) @(posedge clk);
        error_cnt++;
        final_report();
    end

    initial
    begin
        reset_n = 1'h0;
        psel = 1'h0;
        penable = 1'h0;
        pwrite = 1'h0;
        paddr = 8'h00;
        pwdata = 32'h0;
        oe_n = 1'h0;
        repeat (2) @(posedge clk);
        reset_n <= 1'h1;
        repeat (10) @(posedge clk);
        t_straps();
        t_shadow();
        t_words();
        t_order();
        t_apb_err();
        final_report();
    end
endmodule
`default_nettype wire
